// ---- rtl/acwr_receiver.sv ----
`timescale 1ns/1ps
// Functional notes
// - word is the last thirty-two serial bits; fewer is rejected
// - fixed field positions volume treble bass etc
// - surround bit zero means matrix on
// - bits 20..23 drive ports, one is on
// - ports reset off; other settings not reset
// - volume all ones is zero attenuation
module acwr_receiver
(
  input  wire logic        clk_in,               // system clock, 250 MHz
  input  wire logic        sys_rst_in,           // async reset, active high
  input  wire logic        ce_in,                // clock enable, freezes the clk_in-side state; the link shift register and bit count still run
  input  wire logic        serial_shift_clock,   // link clock from host
  input  wire logic        serial_data_in,       // serial data line
  input  wire logic        latch_in,             // latch line from host
  output logic [7:0]       volume_out,           // attenuation code
  output logic [4:0]       treble_out,           // treble code
  output logic [4:0]       bass_out,             // bass code
  output logic             surround_one_on_out,  // matrix one active
  output logic             surround_two_on_out,  // matrix two active
  output logic             open_collector_output_one,   // port one transistor on
  output logic             open_collector_output_two,   // port two transistor on
  output logic             open_collector_output_three, // port three transistor on
  output logic             open_collector_output_four,  // port four transistor on
  output logic             word_taken_out,       // one-cycle pulse on accepted word
  output logic             word_rejected_out     // one-cycle pulse on rejected word
);

  // ---------------------------------------------------------------
  // link domain: shift register on the serial clock
  // ---------------------------------------------------------------
  logic [31:0] shift_q;          // assembled bits, newest at bit 31
  logic [5:0]  cnt_q;            // bits seen since last capture, saturating
  logic        cnt_clr_q;        // clk-side pulse, clears the bit count
  logic        lat_rst;          // async clear of the bit count

  // the count must survive the latch rise until the clk side has taken it,
  // so the clear comes from the clk side one cycle after capture; the link
  // clock stands still while latch is high, so the clear is released with
  // no link edge near it and needs no synchroniser of its own
  assign lat_rst = sys_rst_in | cnt_clr_q;

  // lsb first: after 32 edges bit0 sits at shift_q[0]
  always_ff @(posedge serial_shift_clock or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      shift_q <= 32'h0000_0000;
    else if (!latch_in)
      shift_q <= {serial_data_in, shift_q[31:1]};
  end

  // bit counter, saturates so extra clocks do not wrap
  // no counting while latch is high, same as the shift register
  always_ff @(posedge serial_shift_clock or posedge lat_rst)
  begin
    if (lat_rst)
      cnt_q <= acwr_pkg::CNT_RESET;
    else if (!latch_in && (cnt_q != acwr_pkg::CNT_FULL))
      cnt_q <= cnt_q + 6'h01;
  end

  // ---------------------------------------------------------------
  // crossing: latch level through four flops, word then stable
  // ---------------------------------------------------------------
  logic lat_s;                   // filtered latch level in clk domain
  logic lat_prev_q;              // previous filtered level
  logic lat_rise;                // latch pulse start

  acwr_sync3 u_lat_sync
  (
    .clk_in (clk_in),
    .rst_in (sys_rst_in),
    .ce_in  (ce_in),
    .d_in   (latch_in),
    .q_out  (lat_s)
  );

  // edge detect on the filtered level only
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      lat_prev_q <= 1'b0;
    else if (ce_in)
      lat_prev_q <= lat_s;
  end

  // lat_prev_q resets to the idle latch level, so reset release
  // gives no false edge
  assign lat_rise = lat_s & ~lat_prev_q;

  // ---------------------------------------------------------------
  // capture: shift and count are quiet while latch is high, since the
  // host gives setup before the latch and no clock during it
  // ---------------------------------------------------------------
  logic [31:0] cap_q;            // word captured at latch rise
  logic        cap_full_q;       // 32 bits were present
  logic        cap_vld_q;        // capture happened last cycle
  logic        full_now;         // count reached 32

  assign full_now = (cnt_q == acwr_pkg::CNT_FULL);

  // sample link registers; they are static while latch stays high and
  // four clk cycles have passed since it rose, so no bit is in motion
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cap_q      <= 32'h0000_0000;
      cap_full_q <= 1'b0;
      cap_vld_q  <= 1'b0;
    end
    else if (ce_in)
    begin
      cap_vld_q <= lat_rise;
      if (lat_rise)
      begin
        cap_q      <= shift_q;
        cap_full_q <= full_now;
      end
    end
  end

  // ---------------------------------------------------------------
  // count clear: issued once the capture has taken the count
  // ---------------------------------------------------------------
  // a clear straight from the latch pin would empty the count before the
  // synchronised latch edge could sample it, and every word would fail
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      cnt_clr_q <= 1'b0;
    else if (ce_in)
      cnt_clr_q <= cap_vld_q;
  end

  // ---------------------------------------------------------------
  // decode of captured word
  // ---------------------------------------------------------------
  logic [7:0] csel_f;            // chip select field
  logic       csel_ok;           // pattern matches
  logic       accept;            // apply the word
  logic       reject;            // discard the word

  assign csel_f  = cap_q[acwr_pkg::CSEL_LSB +: acwr_pkg::CSEL_W];
  assign csel_ok = (csel_f == acwr_pkg::CSEL_PATTERN);
  assign accept  = cap_vld_q & cap_full_q & csel_ok;
  assign reject  = cap_vld_q & ~(cap_full_q & csel_ok);

  // ---------------------------------------------------------------
  // active settings
  // ---------------------------------------------------------------
  logic [7:0] vol_q;             // volume, ff = 0 dB
  logic [4:0] tre_q;             // treble
  logic [4:0] bas_q;             // bass
  logic [1:0] sur_q;             // surround bits as sent
  logic [3:0] port_q;            // port bits
  logic       taken_q;           // accepted pulse
  logic       rej_q;             // rejected pulse

  // analog settings carry no reset in the real part; here they only load
  // on a good word, the reset-free flops model the undefined start
  always_ff @(posedge clk_in)
  begin
    if (ce_in && accept)
    begin
      vol_q <= cap_q[acwr_pkg::VOL_LSB +: acwr_pkg::VOL_W];
      tre_q <= cap_q[acwr_pkg::TRE_LSB +: acwr_pkg::TRE_W];
      bas_q <= cap_q[acwr_pkg::BAS_LSB +: acwr_pkg::BAS_W];
      sur_q <= {cap_q[acwr_pkg::SUR2_POS], cap_q[acwr_pkg::SUR1_POS]};
    end
  end

  // ports are the only settings with a reset value
  // a rejected word never reaches here, so ports hold through it
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      port_q <= acwr_pkg::PORT_RESET;
    else if (ce_in && accept)
      port_q <= cap_q[acwr_pkg::PORT_LSB +: acwr_pkg::PORT_W];
  end

  // status pulses
  // one cycle each; a captured word ends in exactly one of the two
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      taken_q <= 1'b0;
      rej_q   <= 1'b0;
    end
    else if (ce_in)
    begin
      taken_q <= accept;
      rej_q   <= reject;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign volume_out                  = vol_q;
  assign treble_out                  = tre_q;
  assign bass_out                    = bas_q;
  // a zero bit switches its matrix on, so these outputs invert
  assign surround_one_on_out         = ~sur_q[0];
  assign surround_two_on_out         = ~sur_q[1];
  assign open_collector_output_one   = port_q[0];
  assign open_collector_output_two   = port_q[1];
  assign open_collector_output_three = port_q[2];
  assign open_collector_output_four  = port_q[3];
  assign word_taken_out              = taken_q;
  assign word_rejected_out           = rej_q;

  // ---------------------------------------------------------------
  // checks
  // link-domain values are read here only while latch is high, when the
  // host keeps the link clock still and they stand
  // ---------------------------------------------------------------
  AST_PORT_HOLD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && !accept) |=> $stable(port_q))
    else $error("ports changed without an accepted word");

  AST_PORT_LOAD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && accept) |=> (port_q == $past(cap_q[23:20])))
    else $error("ports do not follow bits 20 to 23");

  AST_BAD_CSEL: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && cap_vld_q && !csel_ok) |=> (rej_q && !taken_q))
    else $error("bad chip select word not rejected");

  AST_SHORT_WORD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && cap_vld_q && !cap_full_q) |=> !taken_q)
    else $error("short word accepted");

  AST_ACCEPT_TIME: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && lat_rise && full_now &&
     shift_q[acwr_pkg::CSEL_LSB +: acwr_pkg::CSEL_W] == acwr_pkg::CSEL_PATTERN) ##1 ce_in |=> taken_q)
    else $error("good word not accepted two cycles after latch rise");

  AST_SUR_ONE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && accept) |=> (surround_one_on_out == !$past(cap_q[18])))
    else $error("matrix one polarity wrong");

  AST_SUR_TWO: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && accept) |=> (surround_two_on_out == !$past(cap_q[19])))
    else $error("matrix two polarity wrong");

  AST_VOL_LOAD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && accept) |=> (volume_out == $past(cap_q[7:0])))
    else $error("volume not taken from bits 0 to 7");

  AST_PULSE_EXCL: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !(taken_q && rej_q))
    else $error("word both taken and rejected");

  // ---------------------------------------------------------------
  // checks on the count hand-over, field loads, status pulses and port reset
  // ---------------------------------------------------------------
  AST_TRE_LOAD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && accept) |=> (treble_out == $past(cap_q[12:8])))
    else $error("treble not taken from bits 8 to 12");

  AST_BAS_LOAD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && accept) |=> (bass_out == $past(cap_q[17:13])))
    else $error("bass not taken from bits 13 to 17");

  AST_SHORT_REJ: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && cap_vld_q && !cap_full_q) |=> rej_q)
    else $error("short word not rejected");

  AST_TAKEN_ONE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && taken_q) |=> !taken_q)
    else $error("taken pulse longer than one cycle");

  AST_REJ_ONE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && rej_q) |=> !rej_q)
    else $error("rejected pulse longer than one cycle");

  AST_NO_PULSE_IDLE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && !cap_vld_q) |=> !(taken_q || rej_q))
    else $error("status pulse without a capture");

  AST_CLR_DONE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && cap_vld_q) |=> cnt_clr_q)
    else $error("bit count clear not issued after capture");

  AST_CNT_CLEAR: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    cnt_clr_q |-> (cnt_q == acwr_pkg::CNT_RESET))
    else $error("bit count not empty during clear");

  AST_CNT_SAT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (cnt_q <= acwr_pkg::CNT_FULL))
    else $error("bit count beyond thirty-two");

  AST_PORT_RESET_OFF: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> (port_q == acwr_pkg::PORT_RESET))
    else $error("ports not off after reset");

endmodule

// ---- rtl/acwr_pkg.sv ----
package acwr_pkg;
  // ---------------------------------------------------------------
  // control word layout
  // ---------------------------------------------------------------
  localparam int unsigned WORD_BITS      = 32;   // bits per transfer
  localparam int unsigned VOL_LSB        = 0;    // volume field
  localparam int unsigned VOL_W          = 8;
  localparam int unsigned TRE_LSB        = 8;    // treble field
  localparam int unsigned TRE_W          = 5;
  localparam int unsigned BAS_LSB        = 13;   // bass field
  localparam int unsigned BAS_W          = 5;
  localparam int unsigned SUR1_POS       = 18;   // matrix one enable, low active
  localparam int unsigned SUR2_POS       = 19;   // matrix two enable, low active
  localparam int unsigned PORT_LSB       = 20;   // port outputs one..four
  localparam int unsigned PORT_W         = 4;
  localparam int unsigned CSEL_LSB       = 24;   // chip select plus parity
  localparam int unsigned CSEL_W         = 8;
  // pattern bit24..bit31 = 0,1,0,1,0,1,1,1, so word[31:24] = 8'hEA
  localparam logic [7:0]  CSEL_PATTERN   = 8'hEA;
  localparam logic [3:0]  PORT_RESET     = 4'h0; // all ports off
  localparam logic [5:0]  CNT_RESET      = 6'h00;
  localparam logic [5:0]  CNT_FULL       = 6'h20; // 32 bits seen
endpackage

// ---- rtl/acwr_sync3.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// three-stage pin synchroniser, change accepted when 2nd and 3rd agree
// ---------------------------------------------------------------
module acwr_sync3
(
  input  wire logic clk_in,     // destination clock
  input  wire logic rst_in,     // async reset, active high
  input  wire logic ce_in,      // clock enable
  input  wire logic d_in,       // asynchronous level
  output logic      q_out       // filtered level
);
  logic s1_q;                   // metastability catcher, read only by s2
  logic s2_q;
  logic s3_q;
  logic q_q;                    // accepted level

  // shift chain, first stage feeds only the second
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      q_q  <= 1'b0;
    end
    else if (ce_in)
    begin
      s1_q <= d_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // only update once two samples agree
      if (s2_q == s3_q)
        q_q <= s3_q;
    end
  end

  assign q_out = q_q;
endmodule

// ---- sim/acwr_host_model.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// host side of the three-line serial control link
// ---------------------------------------------------------------
module acwr_host_model
(
  output logic sck_out,   // link clock, still outside frames
  output logic sdata_out, // serial data, lsb first
  output logic latch_out  // latch, active high
);
  // all lines low from power-up on
  initial
  begin
    sck_out   = 1'b0;
    sdata_out = 1'b0;
    latch_out = 1'b0;
  end
  // one frame: nbits link clocks at 15 ns, then one latch pulse
  // odd start offset keeps the link out of phase with clk_in
  task automatic send(input logic [31:0] w, input int nbits);
    #3.3;
    for (int i = 0; i < nbits; i++)
    begin
      sdata_out = w[i];
      #7.5 sck_out = 1'b1;
      #7.5 sck_out = 1'b0;
    end
    // latch setup after the last edge, pulse wide enough for the sync
    #7.5 latch_out = 1'b1;
    sdata_out = 1'b0;
    #45 latch_out = 1'b0;
    #15;
  endtask
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`define CHECK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module testbench;
  // ---------------------------------------------------------------
  // stimulus and design
  // ---------------------------------------------------------------
  logic        clk_in = 1'b0;     // 250 MHz system clock
  logic        sys_rst_in;        // raised before the first edge, held 16 cycles
  logic        ce_in = 1'b1;      // clock enable, dropped in one scenario
  logic        sck, sdata, latch; // link lines from host
  logic [7:0]  volume_out;
  logic [4:0]  treble_out, bass_out;
  logic        s1_on, s2_on, p1, p2, p3, p4, word_taken_out, word_rejected_out;
  logic [31:0] ev = {12'h000, 20'hXXXXX}; // last accepted word, ports off
  int          fails = 0;
  int          tests_run = 0;
  always #2 clk_in = ~clk_in;
  acwr_host_model host_i (.sck_out(sck), .sdata_out(sdata), .latch_out(latch));
  acwr_receiver acwr_receiver_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
    .serial_shift_clock(sck), .serial_data_in(sdata), .latch_in(latch),
    .volume_out(volume_out), .treble_out(treble_out), .bass_out(bass_out),
    .surround_one_on_out(s1_on), .surround_two_on_out(s2_on),
    .open_collector_output_one(p1), .open_collector_output_two(p2),
    .open_collector_output_three(p3), .open_collector_output_four(p4),
    .word_taken_out(word_taken_out), .word_rejected_out(word_rejected_out));
  // ---------------------------------------------------------------
  // transfer and compare
  // ---------------------------------------------------------------
  // watch for either pulse while the frame runs; bounded wait
  task automatic xfer(input logic [31:0] w, input int n, input logic good);
    logic tk;
    logic rj;
    tk = 1'b0;
    rj = 1'b0;
    fork
      host_i.send(w, n);
      for (int k = 0; k < 400 && !tk && !rj; k++)
      begin
        @(negedge clk_in);
        tk = (word_taken_out === 1'b1);
        rj = (word_rejected_out === 1'b1);
      end
    join
    `CHECK(tk, good)
    `CHECK(rj, !good)
    if (good)
      ev = w;
    compare();
  endtask
  // settings must equal the last accepted word, rejects change nothing
  task automatic compare;
    `CHECK(volume_out, ev[7:0])
    `CHECK(treble_out, ev[12:8])
    `CHECK(bass_out, ev[17:13])
    `CHECK(s1_on, !ev[18])
    `CHECK(s2_on, !ev[19])
    `CHECK({p4, p3, p2, p1}, ev[23:20])
  endtask
  task automatic close_out;
    $display("TB: checks %0d, errors %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial
  begin
    // a real rising edge, so flops cleared only by reset see it
    #1 sys_rst_in = 1'b1;
    repeat (16) @(negedge clk_in);
    sys_rst_in = 1'b0;
    repeat (20) @(negedge clk_in);
    `CHECK({p4, p3, p2, p1}, 4'h0)
    xfer({8'h6A, 4'hF, 2'b00, 5'h01, 5'h02, 8'h03}, 32, 1'b0);
    xfer({8'hEA, 4'hA, 2'b10, 5'h13, 5'h0F, 8'hFF}, 32, 1'b1);
    xfer({8'hEA, 4'h5, 2'b01, 5'h0C, 5'h1F, 8'h00}, 32, 1'b1);
    xfer({8'hEB, 4'hF, 2'b11, 5'h00, 5'h00, 8'h55}, 32, 1'b0);
    xfer({8'hEA, 4'hF, 2'b00, 5'h1F, 5'h00, 8'h81}, 31, 1'b0);
    // frozen block: a whole word passes while ce_in is low and is lost
    @(negedge clk_in);
    ce_in = 1'b0;
    host_i.send({8'hEA, 4'h6, 2'b01, 5'h02, 5'h03, 8'h04}, 32);
    @(negedge clk_in);
    ce_in = 1'b1;
    repeat (10) @(negedge clk_in);
    compare();
    xfer({8'hEA, 4'hF, 2'b11, 5'h00, 5'h15, 8'h7E}, 32, 1'b1);
    // mid-run reset: only the ports return to off
    sys_rst_in = 1'b1;
    repeat (4) @(negedge clk_in);
    sys_rst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    `CHECK({p4, p3, p2, p1}, 4'h0)
    ev[23:20] = 4'h0;
    xfer({8'hEA, 4'h3, 2'b00, 5'h0A, 5'h14, 8'hC6}, 32, 1'b1);
    close_out();
  end
  // hang guard, about four times the expected run
  initial
  begin
    #20000;
    fails++;
    close_out();
  end
endmodule
